// File: hw/ipcp_target.v
`timescale 1ns/1ps
`include "ipcp_defs.vh"

module ipcp_target #(
    parameter PAGE_BITS = 2,
    parameter BOOK_BITS = 1
) (
    input  wire       mclk_i,
    input  wire       sys_rst_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output wire       sda_o,
    output reg        sda_oe_o,
    input  wire [1:0] adr_strap_i,
    output reg  [7:0] page_o,
    output reg  [7:0] book_o,
    output reg        wr_stb_o,
    output reg  [7:0] wr_sub_o,
    output reg  [7:0] wr_data_o
);
    localparam AW = BOOK_BITS + PAGE_BITS + 8;

    localparam [7:0] S_IDLE = 8'h01;
    localparam [7:0] S_ADDR = 8'h02;
    localparam [7:0] S_SUB  = 8'h04;
    localparam [7:0] S_WDAT = 8'h08;
    localparam [7:0] S_ACK  = 8'h10;
    localparam [7:0] S_RDAT = 8'h20;
    localparam [7:0] S_RACK = 8'h40;
    localparam [7:0] S_WAIT = 8'h80;

    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    reg [1:0] scl_sync;
    reg [1:0] sda_sync;
    reg       scl_d;
    reg       sda_d;
    reg [1:0] strap_s1;
    reg [1:0] strap_s2;
    reg [1:0] strap;
    reg [1:0] strap_cnt;

    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
            strap_s1 <= 2'h0;
            strap_s2 <= 2'h0;
        end else begin
            scl_sync <= {scl_sync[0], scl_i};
            sda_sync <= {sda_sync[0], sda_i};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
            strap_s1 <= adr_strap_i;
            strap_s2 <= strap_s1;
        end
    end

    wire scl_s    = scl_sync[1];
    wire sda_s    = sda_sync[1];
    // both bus rates
    // Oversampling keeps edges exact at either rate as long as each phase spans 4 clocks
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire bus_strt = scl_s & scl_d & sda_d & ~sda_s;
    wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

    // strap capture
    // Strap is re-read whenever SCL and SDA are both high and page_o[0] is clear, so it can move during a frame
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            strap_cnt <= 2'h0;
            strap     <= 2'h0;
        end else if (strap_cnt != `IPCP_STRAP_WAIT) begin
            strap_cnt <= strap_cnt + 2'h1;
        end else if (strap_cnt == `IPCP_STRAP_WAIT && scl_s && sda_s && !page_o[0]) begin
            strap <= strap_s2;
        end
    end

    // ****************************************
    // Transfer state
    // ****************************************
    reg [7:0] state;
    reg [7:0] after_ack;
    reg [2:0] bit_cnt;
    reg [6:0] rx;
    reg [7:0] tx;
    reg [7:0] sub;
    reg       ack_pend;
    reg       m_ack;
    reg       mem_we;
    reg [7:0] mem_wd;
    wire [7:0] mem_rd;
    wire [7:0] rx_byte = {rx, sda_s};

    wire [AW-1:0] mem_idx = {book_o[BOOK_BITS-1:0], page_o[PAGE_BITS-1:0], sub};
    reg  [AW-1:0] mem_widx;

    // page register read back at sub-address zero
    // book register read back on page zero
    wire [7:0] rd_byte = (sub == `IPCP_SUB_PAGE) ? page_o :
                         ((page_o == `IPCP_PAGE_ZERO) && (sub == `IPCP_SUB_BOOK)) ? book_o :
                         mem_rd;

    // Open drain: the line is only ever pulled low
    assign sda_o = 1'b0;

    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state     <= S_IDLE;
            after_ack <= S_IDLE;
            bit_cnt   <= 3'h0;
            rx        <= 7'h00;
            tx        <= `IPCP_BYTE_RST;
            sub       <= `IPCP_BYTE_RST;
            ack_pend  <= 1'b0;
            m_ack     <= 1'b0;
            sda_oe_o  <= 1'b0;
            page_o    <= `IPCP_BYTE_RST;
            book_o    <= `IPCP_BYTE_RST;
            wr_stb_o  <= 1'b0;
            wr_sub_o  <= `IPCP_BYTE_RST;
            wr_data_o <= `IPCP_BYTE_RST;
            mem_we    <= 1'b0;
            mem_wd    <= `IPCP_BYTE_RST;
            mem_widx  <= {AW{1'b0}};
        end else begin
            wr_stb_o <= 1'b0;
            mem_we   <= 1'b0;
            if (bus_strt) begin
                state    <= S_ADDR;
                bit_cnt  <= 3'h0;
                ack_pend <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (bus_stop) begin
                state    <= S_IDLE;
                ack_pend <= 1'b0;
                sda_oe_o <= 1'b0;
            end else begin
                case (state)
                    S_ADDR, S_SUB, S_WDAT: begin
                        if (scl_rise) begin
                            rx      <= rx_byte[6:0];
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == `IPCP_LAST_BIT) begin
                                ack_pend <= 1'b1;
                                if (state == S_ADDR) begin
                                    if (rx_byte[7:1] == {`IPCP_ADDR_HI, strap}) begin
                                        after_ack <= rx_byte[0] ? S_RDAT : S_SUB;
                                    end else begin
                                        ack_pend <= 1'b0;
                                        state    <= S_WAIT;
                                    end
                                end else if (state == S_SUB) begin
                                    sub       <= rx_byte;
                                    after_ack <= S_WDAT;
                                end else begin
                                    after_ack <= S_WDAT;
                                    sub       <= sub + `IPCP_SUB_STEP;
                                    wr_stb_o  <= 1'b1;
                                    wr_sub_o  <= sub;
                                    wr_data_o <= rx_byte;
                                    if (sub == `IPCP_SUB_PAGE) begin
                                        page_o <= rx_byte;
                                    end else if (page_o == `IPCP_PAGE_ZERO &&
                                                 sub == `IPCP_SUB_BOOK) begin
                                        book_o <= rx_byte;
                                    end else begin
                                        mem_we   <= 1'b1;
                                        mem_wd   <= rx_byte;
                                        mem_widx <= mem_idx;
                                    end
                                end
                            end
                        end else if (scl_fall && ack_pend) begin
                            ack_pend <= 1'b0;
                            sda_oe_o <= 1'b1;
                            state    <= S_ACK;
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            bit_cnt <= 3'h0;
                            state   <= after_ack;
                            if (after_ack == S_RDAT) begin
                                tx       <= {rd_byte[6:0], 1'b0};
                                sda_oe_o <= ~rd_byte[7];
                                sub      <= sub + `IPCP_SUB_STEP;
                            end else begin
                                sda_oe_o <= 1'b0;
                            end
                        end
                    end
                    S_RDAT: begin
                        if (scl_fall) begin
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == `IPCP_LAST_BIT) begin
                                sda_oe_o <= 1'b0;
                                state    <= S_RACK;
                            end else begin
                                sda_oe_o <= ~tx[7];
                                tx       <= {tx[6:0], 1'b0};
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise) begin
                            m_ack <= ~sda_s;
                        end else if (scl_fall) begin
                            bit_cnt <= 3'h0;
                            if (m_ack) begin
                                tx       <= {rd_byte[6:0], 1'b0};
                                sda_oe_o <= ~rd_byte[7];
                                sub      <= sub + `IPCP_SUB_STEP;
                                state    <= S_RDAT;
                            end else begin
                                state <= S_WAIT;
                            end
                        end
                    end
                    default: begin
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Register and coefficient store
    // ****************************************
    ipcp_mem #(
        .AW (AW)
    ) u_mem (
        .mclk_i    (mclk_i),
        .wr_en_i   (mem_we),
        .wr_addr_i (mem_widx),
        .wr_data_i (mem_wd),
        .rd_addr_i (mem_idx),
        .rd_data_o (mem_rd)
    );
endmodule // ipcp_target

// File: hw/ipcp_defs.vh
`ifndef IPCP_DEFS_VH
`define IPCP_DEFS_VH

// ****************************************
// Target address and register locations
// ****************************************
`define IPCP_ADDR_HI      5'h13
`define IPCP_SUB_PAGE     8'h00
`define IPCP_SUB_BOOK     8'h7f
`define IPCP_PAGE_ZERO    8'h00
`define IPCP_BYTE_RST     8'h00
`define IPCP_LAST_BIT     3'h7
`define IPCP_STRAP_WAIT   2'h2
`define IPCP_SUB_STEP     8'h01

`endif

// File: hw/ipcp_mem.v
`timescale 1ns/1ps

// ****************************************
// Register and coefficient store
// ****************************************
module ipcp_mem #(
    parameter AW = 10
) (
    input  wire          mclk_i,
    input  wire          wr_en_i,
    input  wire [AW-1:0] wr_addr_i,
    input  wire [7:0]    wr_data_i,
    input  wire [AW-1:0] rd_addr_i,
    output reg  [7:0]    rd_data_o
);
    reg [7:0] store [0:(1<<AW)-1];

    // No reset on the array so it maps onto block RAM
    always @(posedge mclk_i) begin
        if (wr_en_i) begin
            store[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= store[rd_addr_i];
    end
endmodule // ipcp_mem

// File: sim/ipcp_target_assertions.sv
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module ipcp_chk (
    input wire logic       mclk_i,
    input wire logic       sys_rst_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic [1:0] adr_strap_i,
    input wire logic [7:0] page_o,
    input wire logic [7:0] book_o,
    input wire logic       wr_stb_o,
    input wire logic [7:0] wr_sub_o,
    input wire logic [7:0] wr_data_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // Checked one edge later: the first reset edge may still see unset registers
    rst_quiet_a: assert property (disable iff (1'b0) sys_rst_i |=>
        page_o == 8'h00 && book_o == 8'h00 && !wr_stb_o && !sda_oe_o) else $error("reset state");
    sda_const_a: assert property (sda_o == 1'b0) else $error("drive value not low");
    // Bench SCL gives at least 7 cycles per driven bit
    oe_hold_a: assert property ($rose(sda_oe_o) |-> sda_oe_o[*6]) else $error("short drive");
    stb_pulse_a: assert property (wr_stb_o |=> !wr_stb_o) else $error("long strobe");
    wr_hold_a: assert property (!wr_stb_o |-> $stable(wr_sub_o) && $stable(wr_data_o))
        else $error("write bus moved");
    page_src_a: assert property ($changed(page_o) |->
        ##[0:1] (wr_sub_o == 8'h00 && wr_data_o == page_o)) else $error("page moved alone");
    page_set_a: assert property (wr_stb_o && wr_sub_o == 8'h00 |-> ##[0:1] page_o == wr_data_o)
        else $error("page not taken");
    book_src_a: assert property ($changed(book_o) |->
        ##[0:1] (wr_sub_o == 8'h7f && wr_data_o == book_o)) else $error("book moved alone");
    book_set_a: assert property (wr_stb_o && wr_sub_o == 8'h7f && page_o == 8'h00
        |-> ##[0:1] book_o == wr_data_o) else $error("book not taken");
    cover property (wr_stb_o && wr_sub_o == 8'h7f);
    cover property ($rose(sda_oe_o));
    cover property ($changed(page_o));
endmodule // ipcp_chk

bind ipcp_target ipcp_chk ipcp_chk_i (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .adr_strap_i(adr_strap_i), .page_o(page_o), .book_o(book_o),
    .wr_stb_o(wr_stb_o), .wr_sub_o(wr_sub_o), .wr_data_o(wr_data_o));

// File: sim/ipcp_host.sv
`timescale 1ns/1ps
// ****************************************
// Bus controller model
// ****************************************
module ipcp_host (
    input  wire logic mclk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // start framing
    // Waits out the device release first
    task automatic start;
        sda_oe_o = 1'b0;
        tick(5);
        scl_o = 1'b1;
        tick(4);
        sda_oe_o = 1'b1;
        tick(4);
        scl_o = 1'b0;
    endtask
    task automatic stop;
        tick(2);
        sda_oe_o = 1'b1;
        tick(3);
        scl_o = 1'b1;
        tick(4);
        sda_oe_o = 1'b0;
        tick(4);
    endtask
    // Data changes mid low phase, sampled mid high phase
    task automatic put_bit(input logic b, output logic r);
        tick(2);
        sda_oe_o = ~b;
        tick(2);
        scl_o = 1'b1;
        tick(2);
        r = sda_i;
        tick(2);
        scl_o = 1'b0;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) put_bit(d[i], r);
        put_bit(1'b1, r);
        ack = ~r;
    endtask
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            d[i] = r;
        end
        put_bit(last, r);
    endtask
endmodule // ipcp_host

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [1:0] s; logic [6:0] a; logic [7:0] b; logic [7:0] d; logic k;} ipcp_row_t;
    logic       mclk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [1:0] adr_strap_i = 2'h0;
    logic       scl_w, host_oe, sda_o, sda_oe_o, wr_stb_o;
    logic [7:0] page_o, book_o, wr_sub_o, wr_data_o;
    // Pull-up: the line is high unless one side drives its low value
    wire        sda_w = (sda_oe_o ? sda_o : 1'b1) & ~host_oe;
    int         miscompares = 0;
    int         comparisons = 0;
    logic [15:0] wq[$];
    ipcp_row_t rows[6] = '{'{2'h0, 7'h4C, 8'h10, 8'hA5, 1'b1}, '{2'h1, 7'h4D, 8'h21, 8'h3C, 1'b1},
        '{2'h2, 7'h4E, 8'h42, 8'hC3, 1'b1}, '{2'h3, 7'h4F, 8'hFF, 8'h81, 1'b1},
        '{2'h2, 7'h4D, 8'h33, 8'h77, 1'b0}, '{2'h3, 7'h4B, 8'h34, 8'h66, 1'b0}};
    initial forever #20 mclk_i = ~mclk_i;
    ipcp_target ipcp_target_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_w),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .adr_strap_i(adr_strap_i),
        .page_o(page_o), .book_o(book_o), .wr_stb_o(wr_stb_o), .wr_sub_o(wr_sub_o),
        .wr_data_o(wr_data_o));
    ipcp_host ipcp_host_i (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_oe_o(host_oe));
    always @(negedge mclk_i) if (wr_stb_o === 1'b1) wq.push_back({wr_sub_o, wr_data_o});
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Strap is re-read whenever both lines sit high and page_o[0] is clear, not only after reset; each strap still gets its own reset
    task automatic do_rst(input logic [1:0] s);
        @(negedge mclk_i);
        sys_rst_i = 1'b1;
        adr_strap_i = s;
        repeat (4) @(negedge mclk_i);
        chk({page_o, book_o}, 16'h0000, "reset regs");
        chk({wr_sub_o, wr_data_o}, 16'h0000, "reset write bus");
        sys_rst_i = 1'b0;
        repeat (6) @(negedge mclk_i);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] b, input logic [7:0] d[$], output logic k);
        logic x;
        wq.delete();
        ipcp_host_i.start();
        ipcp_host_i.send({a, 1'b0}, k);
        ipcp_host_i.send(b, x);
        k = k & x;
        foreach (d[i]) begin
            ipcp_host_i.send(d[i], x);
            k = k & x;
        end
        ipcp_host_i.stop();
    endtask
    task automatic rd(input logic [7:0] b, input int n, output logic [7:0] q[$], output logic k);
        logic x;
        logic [7:0] v;
        q = {};
        ipcp_host_i.start();
        ipcp_host_i.send({7'h4C, 1'b0}, k);
        ipcp_host_i.send(b, x);
        k = k & x;
        ipcp_host_i.start();
        ipcp_host_i.send({7'h4C, 1'b1}, x);
        k = k & x;
        for (int i = 0; i < n; i++) begin
            ipcp_host_i.recv(i == n - 1, v);
            q.push_back(v);
        end
        ipcp_host_i.stop();
    endtask
    initial begin
        repeat (100000) @(posedge mclk_i);
        miscompares++;
        complete_run();
    end
    initial begin
        logic k;
        logic [7:0] q[$];
        foreach (rows[i]) begin
            do_rst(rows[i].s);
            wr(rows[i].a, rows[i].b, '{rows[i].d}, k);
            chk(16'(k), 16'(rows[i].k), "ack");
            chk(16'(wq.size()), 16'(rows[i].k), "store count");
            if (rows[i].k && rows[i].s == 2'h0) begin
                rd(rows[i].b, 1, q, k);
                chk({7'h00, k, q[0]}, {8'h01, rows[i].d}, "read back");
            end
            if (rows[i].k) chk(wq[0], {rows[i].b, rows[i].d}, "stored");
            $display("row %0d done", i);
        end
        do_rst(2'h0);
        wr(7'h4C, 8'hFE, '{8'h11, 8'h22, 8'h02}, k);
        chk(wq[1], 16'hFF22, "wrap write");
        chk(16'(k), 16'h0001, "wrap ack");
        chk({wq[2][15:8], page_o}, 16'h0002, "page select");
        rd(8'h00, 1, q, k);
        chk(16'(q[0]), 16'h0002, "page read");
        wr(7'h4C, 8'h10, '{8'h5A}, k);
        wr(7'h4C, 8'h00, '{8'h00}, k);
        wr(7'h4C, 8'h10, '{8'hA5}, k);
        rd(8'h10, 1, q, k);
        chk(16'(q[0]), 16'h00A5, "page zero store");
        wr(7'h4C, 8'h00, '{8'h02}, k);
        rd(8'h10, 1, q, k);
        chk(16'(q[0]), 16'h005A, "page two store");
        $display("page test done");
        wr(7'h4C, 8'h00, '{8'h00}, k);
        wr(7'h4C, 8'h7F, '{8'h01}, k);
        chk({book_o, page_o}, 16'h0100, "book select");
        wr(7'h4C, 8'h00, '{8'h01}, k);
        wr(7'h4C, 8'h7F, '{8'h33}, k);
        rd(8'h7F, 1, q, k);
        chk({book_o, q[0]}, 16'h0133, "book kept");
        $display("book test done");
        wr(7'h4C, 8'h30, '{8'hC1, 8'hC2, 8'hC3}, k);
        rd(8'h30, 3, q, k);
        chk({q[0], q[1]}, 16'hC1C2, "burst read");
        chk({7'h00, k, q[2]}, 16'h01C3, "burst tail");
        $display("burst test done");
        complete_run();
    end
endmodule // tb_top
